// *** tb/dfc_datapath_fifo_control_bench.sv ***
`timescale 1ns/10ps
module dfc_datapath_fifo_control_bench;
  localparam logic [7:0] A0V = 8'h3c;
  localparam logic [7:0] A1V = 8'hc3;
  localparam logic [3:0] AUX = dfc_pkg::DFC_OFS_AUX_CTRL,
    MOD = dfc_pkg::DFC_OFS_MODE_CFG, DYN = dfc_pkg::DFC_OFS_DYN_CFG,
    RTE = dfc_pkg::DFC_OFS_ROUTE_CFG, AC0 = dfc_pkg::DFC_OFS_ACC0,
    AC1 = dfc_pkg::DFC_OFS_ACC1, FI0 = dfc_pkg::DFC_OFS_FIFO0,
    FI1 = dfc_pkg::DFC_OFS_FIFO1, STA = dfc_pkg::DFC_OFS_STATUS;
  logic clk_sys_i = 1'b0;
  logic rstn_i = 1'b0;
  dfc_pkg::dfc_bus_req_t req = '0;
  dfc_pkg::dfc_dp_data_t dp_data;
  logic [1:0] hw = 2'h0, sel = 2'h0, chin = 2'h0, pop = 2'h0;
  logic [1:0] dp_rd, host, intl, wp, chout;
  logic [1:0][7:0] fdat;
  logic [7:0] rdd, d;
  logic dp_clk;
  int n_mismatch = 0, check_count = 0, cyc = 0, np = 0, d0, d1;
  always #2.5 clk_sys_i = ~clk_sys_i;
  dfc_datapath_fifo_control uut (.clk_sys_i(clk_sys_i), .rstn_i(rstn_i),
    .bus_req_i(req), .rd_data_o(rdd), .dp_clk_i(dp_clk),
    .hw_load_strobe_i(hw), .access_select_i(sel), .capture_chain_i(chin),
    .dp_data_i(dp_data), .dp_read_i(dp_rd), .fifo_data_o(fdat),
    .host_side_status_o(host), .internal_side_status_o(intl),
    .fifo_write_pulse_o(wp), .capture_chain_o(chout));
  dfc_dp_model #(.ACC0(A0V), .ACC1(A1V)) dpm (.clk_sys_i(clk_sys_i),
    .rstn_i(rstn_i), .pop_i(pop), .dp_clk_o(dp_clk), .dp_read_o(dp_rd),
    .dp_data_o(dp_data));
  always @(posedge clk_sys_i) begin
    cyc++;
    if (wp[0] === 1'b1) np++;
    if (cyc == 20000) begin
      n_mismatch++;
      final_report();
    end
  end
  task automatic chk(input string nm, input logic [7:0] e, g);
    check_count++;
    if (g !== e) begin
      n_mismatch++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic idle(input int n);
    repeat (n) @(posedge clk_sys_i);
    #1;
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] v);
    @(posedge clk_sys_i);
    req <= {1'b1, 1'b0, a, v};
    @(posedge clk_sys_i);
    req <= '0;
  endtask
  task automatic rd(input logic [3:0] a);
    @(posedge clk_sys_i);
    req <= {1'b0, 1'b1, a, 8'h00};
    @(posedge clk_sys_i);
    req <= '0;
    #1 d = rdd;
  endtask
  task automatic rchk(input string nm, input logic [3:0] a, logic [7:0] e);
    rd(a);
    chk(nm, e, d);
  endtask
  task automatic st(input logic [7:0] e);
    idle(4);
    rchk("status", STA, e);
  endtask
  // Flush both FIFOs, then release with the given levels
  task automatic clr(input logic [7:0] lv);
    wr(AUX, 8'h03 | lv);
    wr(AUX, lv);
  endtask
  task automatic dpop(input int i);
    @(posedge clk_sys_i);
    pop[i] <= 1'b1;
    for (int k = 0; k < 40 && dp_rd[i] !== 1'b1; k++) @(posedge clk_sys_i);
    pop[i] <= 1'b0;
    for (int k = 0; k < 40 && dp_rd[i] !== 1'b0; k++) @(posedge clk_sys_i);
    idle(4);
  endtask
  task automatic t_reset;
    st(8'h0f);
    rchk("unmapped", 4'hf, 8'h00);
    rchk("aux", AUX, dfc_pkg::DFC_RST_AUX_CTRL);
    $display("t_reset done");
  endtask
  task automatic t_input;
    clr(8'h04);
    for (int k = 1; k < 4; k++) wr(FI0, 8'(8'h11 * k));
    st(8'h0a);
    wr(AUX, 8'h00);
    st(8'h0b);
    wr(FI0, 8'h44);
    wr(FI0, 8'h55);
    idle(3);
    chk("front", 8'h55, fdat[0]);
    dpop(0);
    chk("front", 8'h22, fdat[0]);
    for (int k = 0; k < 4; k++) dpop(0);
    wr(FI0, 8'h66);
    idle(3);
    chk("front", 8'h66, fdat[0]);
    st(8'h0b);
    wr(MOD, 8'h04);
    dpop(0);
    st(8'h0f);
    wr(MOD, 8'h00);
    $display("t_input done");
  endtask
  task automatic t_flush;
    wr(AUX, 8'h01);
    wr(FI0, 8'h77);
    rchk("held", FI0, 8'h77);
    wr(FI0, 8'h88);
    rchk("held", FI0, 8'h88);
    st(8'h0a);
    wr(AUX, 8'h00);
    st(8'h0f);
    $display("t_flush done");
  endtask
  task automatic meas(output int n);
    wr(FI0, 8'h12);
    n = 0;
    while (intl[0] !== 1'b0 && n < 30) begin
      @(posedge clk_sys_i);
      n++;
    end
  endtask
  task automatic t_async;
    meas(d0);
    clr(8'h00);
    wr(MOD, 8'h02);
    meas(d1);
    chk("async lag", 8'(d0 + 2), 8'(d1));
    st(8'h0b);
    wr(MOD, 8'h00);
    clr(8'h00);
    $display("t_async done");
  endtask
  task automatic t_capture;
    wr(RTE, 8'h09);
    wr(MOD, 8'h31);
    clr(8'h00);
    rd(AC0);
    rchk("cap0", FI0, A0V);
    rd(AC1);
    rchk("cap1", FI1, A1V);
    @(posedge clk_sys_i);
    chin <= 2'h1;
    @(posedge clk_sys_i);
    chin <= 2'h0;
    idle(3);
    rchk("chain", FI0, A0V);
    np = 0;
    @(posedge clk_sys_i);
    hw <= 2'h1;
    repeat (6) @(posedge clk_sys_i);
    hw <= 2'h0;
    idle(3);
    chk("edge writes", 8'h01, 8'(np));
    wr(MOD, 8'h11);
    np = 0;
    @(posedge clk_sys_i);
    hw <= 2'h1;
    repeat (3) @(posedge clk_sys_i);
    hw <= 2'h0;
    idle(3);
    chk("level writes", 8'h03, 8'(np));
    clr(8'h00);
    wr(RTE, 8'h08);
    wr(MOD, 8'h01);
    np = 0;
    rd(AC0);
    idle(3);
    chk("input capture", 8'h00, 8'(np));
    wr(MOD, 8'h00);
    $display("t_capture done");
  endtask
  task automatic t_dyn;
    wr(RTE, 8'h01);
    wr(DYN, 8'h01);
    clr(8'h00);
    sel <= 2'h1;
    idle(3);
    for (int k = 0; k < 4; k++) wr(FI0, 8'(8'h41 + k));
    st(8'h0f);
    @(posedge clk_sys_i);
    sel <= 2'h0;
    idle(3);
    dpop(0);
    st(8'h0b);
    wr(FI0, 8'h99);
    st(8'h0b);
    @(posedge clk_sys_i);
    sel <= 2'h1;
    idle(3);
    wr(AUX, 8'h04);
    rchk("dyn read", FI0, 8'h42);
    rd(FI0);
    st(8'h0a);
    $display("t_dyn done");
  endtask
  task automatic final_report;
    $display("checks %0d mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  initial begin
    repeat (4) @(posedge clk_sys_i);
    rstn_i <= 1'b1;
    t_reset();
    t_input();
    t_flush();
    t_async();
    t_capture();
    t_dyn();
    final_report();
  end
endmodule
bind dfc_datapath_fifo_control dfc_monitor mon (.clk_sys_i(clk_sys_i),
  .rstn_i(rstn_i), .bus_req_i(bus_req_i),
  .hw_load_strobe_i(hw_load_strobe_i), .capture_chain_i(capture_chain_i),
  .host_side_status_o(host_side_status_o),
  .internal_side_status_o(internal_side_status_o),
  .fifo_write_pulse_o(fifo_write_pulse_o),
  .capture_chain_o(capture_chain_o));

// *** tb/dfc_dp_model.sv ***
`timescale 1ns/10ps
module dfc_dp_model #(
  parameter logic [7:0] ACC0 = 8'h00,
  parameter logic [7:0] ACC1 = 8'h00
) (
  input wire logic clk_sys_i,
  input wire logic rstn_i,
  input wire logic [1:0] pop_i,
  output logic dp_clk_o,
  output logic [1:0] dp_read_o,
  output dfc_pkg::dfc_dp_data_t dp_data_o
);
  logic [2:0] cnt_r;
  // Read changes only in the low half so exactly one tick sees it
  always_ff @(posedge clk_sys_i) begin
    if (!rstn_i) begin
      cnt_r <= 3'h0;
      dp_read_o <= 2'h0;
    end else begin
      cnt_r <= cnt_r + 3'h1;
      if (cnt_r == 3'h7) dp_read_o <= pop_i;
    end
  end
  assign dp_clk_o = cnt_r[2];
  assign dp_data_o = '{alu: ACC0 ^ ACC1, acc1: ACC1, acc0: ACC0};
endmodule

// *** tb/dfc_monitor.sv ***
`timescale 1ns/10ps
module dfc_monitor (
  input wire logic clk_sys_i,
  input wire logic rstn_i,
  input dfc_pkg::dfc_bus_req_t bus_req_i,
  input wire logic [1:0] hw_load_strobe_i,
  input wire logic [1:0] capture_chain_i,
  input wire logic [1:0] host_side_status_o,
  input wire logic [1:0] internal_side_status_o,
  input wire logic [1:0] fifo_write_pulse_o,
  input wire logic [1:0] capture_chain_o
);
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!rstn_i);
  logic [7:0] aux_r, mode_r, dyn_r, route_r;
  wire logic we = bus_req_i.we;
  wire logic [3:0] a = bus_req_i.addr;
  wire logic [7:0] w = bus_req_i.wdata;
  // Shadow of the config registers, seen from bus writes only
  always_ff @(posedge clk_sys_i) begin
    if (!rstn_i) begin
      aux_r <= 8'h00;
      mode_r <= 8'h00;
      dyn_r <= 8'h00;
      route_r <= 8'h00;
    end else begin
      if (we && a == dfc_pkg::DFC_OFS_AUX_CTRL) aux_r <= w;
      if (we && a == dfc_pkg::DFC_OFS_MODE_CFG) mode_r <= w;
      if (we && a == dfc_pkg::DFC_OFS_DYN_CFG) dyn_r <= w;
      if (we && a == dfc_pkg::DFC_OFS_ROUTE_CFG) route_r <= w;
    end
  end
  wire logic cap = mode_r[0];
  wire logic out0 = route_r[1:0] != 2'h0 && !dyn_r[0];
  wire logic in0 = route_r[1:0] == 2'h0 && !dyn_r[0];
  wire logic rd_a0 = bus_req_i.re && a == dfc_pkg::DFC_OFS_ACC0;
  wire logic fe = mode_r[4] && mode_r[5] && out0 && !aux_r[0];
  wire logic fl = mode_r[4] && !mode_r[5] && out0 && !aux_r[0];
  sequence held_s;
    hw_load_strobe_i[0] && fe && !bus_req_i.re && !capture_chain_i[0];
  endsequence
  sequence flush_s;
    aux_r[0] [*4];
  endsequence
  chain_rd_a: assert property (cap && rd_a0 |=> capture_chain_o[0])
    else $error("chain out missing after accumulator read");
  chain_in_a: assert property (
    cap && fe && capture_chain_i[0] |-> ##[1:2] fifo_write_pulse_o[0])
    else $error("chain in gave no fifo write");
  sw_write_a: assert property (
    cap && out0 && mode_r[4] && rd_a0 |=> fifo_write_pulse_o[0])
    else $error("accumulator read gave no fifo write");
  in_nocap_a: assert property (
    cap && in0 && rd_a0 |=> !fifo_write_pulse_o[0])
    else $error("capture wrote an input fifo");
  hw_edge_a: assert property (
    fe && $rose(hw_load_strobe_i[0]) |-> ##[1:2] fifo_write_pulse_o[0])
    else $error("strobe edge gave no fifo write");
  edge_once_a: assert property (held_s [*4] |=> !fifo_write_pulse_o[0])
    else $error("held strobe wrote again");
  lvl_each_a: assert property (
    fl && hw_load_strobe_i[0] |-> ##[1:2] fifo_write_pulse_o[0])
    else $error("level strobe cycle gave no write");
  flush_quiet_a: assert property (
    flush_s |-> !host_side_status_o[0] && !internal_side_status_o[0])
    else $error("status shown while flush held");
endmodule

// *** verilog/dfc_byte_fifo.sv ***
`timescale 1ns/10ps
module dfc_byte_fifo (
  input wire logic clk_sys_i,
  input wire logic rstn_i,
  input wire logic flush_i,
  input wire logic wr_i,
  input wire logic [dfc_pkg::DFC_FIFO_W-1:0] wdata_i,
  input wire logic rd_i,
  output logic [dfc_pkg::DFC_FIFO_W-1:0] rdata_o,
  output logic [2:0] count_o
);

  logic [dfc_pkg::DFC_FIFO_W-1:0] mem_r [0:3];
  logic [1:0] wptr_r;
  logic [1:0] rptr_r;
  logic [2:0] cnt_r;
  logic [2:0] cnt_nxt;
  wire full = (cnt_r == dfc_pkg::DFC_FIFO_DEPTH);
  wire empty = (cnt_r == 3'h0);
  // Underflow: a read of an empty FIFO moves nothing
  wire do_rd = rd_i && !empty && !flush_i;
  // Overflow: front entry is replaced, pointers kept
  wire ovw = wr_i && full && !do_rd;
  wire push = wr_i && !ovw && !flush_i;
  // Flushed FIFO is a one-byte buffer at entry zero
  wire [1:0] waddr = flush_i ? 2'h0 : wptr_r;

  assign cnt_nxt = 3'(cnt_r + {2'h0, push} - {2'h0, do_rd});

  always_ff @(posedge clk_sys_i) begin
    if (!rstn_i || flush_i) begin
      wptr_r <= 2'h0;
      rptr_r <= 2'h0;
      cnt_r <= 3'h0;
    end else begin
      wptr_r <= 2'(wptr_r + {1'h0, push});
      rptr_r <= 2'(rptr_r + {1'h0, do_rd});
      cnt_r <= cnt_nxt;
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (wr_i) begin
      mem_r[waddr] <= wdata_i;
    end
  end

  assign rdata_o = mem_r[rptr_r];
  assign count_o = cnt_r;

endmodule

// *** verilog/dfc_datapath_fifo_control.sv ***
// How it works
// - Capture writes only output FIFOs; chain out passes for input FIFOs too
// - Accumulator read writes value into its FIFO
// - Capture trigger passes along the chain
// - Load strobe ORed with software capture
// - Flush bit resets FIFO until cleared
// - Held flush gives one-byte statusless buffer
// - Level bit sets threshold one or two
// - Async empty clears late, sets at once
// - Async full clears late, sets at once
// - One async bit, internal status only
// - Write when full overwrites front entry
// - Empty read undefined, pointers stay sound
// - Clock invert picks falling datapath edge
// - Dynamic bit lets routed signal pick access
// - Internal access reads into accumulator only
// - Access select high external, low internal
// - Dynamic status: write full, read threshold
// - Four status outputs, per FIFO direction
// - Static internal status: input empty, output full
// - Edge mode needs strobe low between edges
// - Fast mode samples strobe every system clock for output-routed FIFOs only
`timescale 1ns/10ps
module dfc_datapath_fifo_control (
  input wire logic clk_sys_i,
  input wire logic rstn_i,
  input dfc_pkg::dfc_bus_req_t bus_req_i,
  output logic [dfc_pkg::DFC_DW-1:0] rd_data_o,
  input wire logic dp_clk_i,
  input wire logic [1:0] hw_load_strobe_i,
  input wire logic [1:0] access_select_i,
  input wire logic [1:0] capture_chain_i,
  input dfc_pkg::dfc_dp_data_t dp_data_i,
  input wire logic [1:0] dp_read_i,
  output logic [1:0][dfc_pkg::DFC_FIFO_W-1:0] fifo_data_o,
  output logic [1:0] host_side_status_o,
  output logic [1:0] internal_side_status_o,
  output logic [1:0] fifo_write_pulse_o,
  output logic [1:0] capture_chain_o
);

  // Software registers
  logic [7:0] aux_r;
  logic [7:0] mode_r;
  logic [7:0] dyn_r;
  logic [7:0] route_r;
  logic [7:0] rd_data_r;
  logic [7:0] rd_data_nxt;

  // Per-FIFO state and outputs
  logic [1:0][7:0] fifo_data_r;
  logic [1:0][7:0] fifo_rdata;
  logic [1:0][2:0] fifo_count;
  logic [1:0] host_stat_r;
  logic [1:0] int_stat_r;
  logic [1:0] wr_pulse_r;
  logic [1:0] chain_r;

  // Pins from routing: datapath clock and access selects
  logic [2:0] pin_sync;
  logic dp_clk_d_r;

  function automatic logic reg_hit(input logic [3:0] addr,
                                   input logic [3:0] ofs);
    reg_hit = (addr == ofs);
  endfunction

  dfc_sync #(
    .WIDTH(3)
  ) u_pin_sync (
    .clk_sys_i(clk_sys_i),
    .rstn_i(rstn_i),
    .d_i({access_select_i, dp_clk_i}),
    .q_o(pin_sync)
  );

  wire dp_clk_s = pin_sync[0];
  wire [1:0] access_sel_s = pin_sync[2:1];
  wire dp_rise = dp_clk_s && !dp_clk_d_r;
  wire dp_fall = !dp_clk_s && dp_clk_d_r;

  // Write decode
  wire wr_aux = bus_req_i.we &&
                reg_hit(bus_req_i.addr, dfc_pkg::DFC_OFS_AUX_CTRL);
  wire wr_mode = bus_req_i.we &&
                 reg_hit(bus_req_i.addr, dfc_pkg::DFC_OFS_MODE_CFG);
  wire wr_dyn = bus_req_i.we &&
                reg_hit(bus_req_i.addr, dfc_pkg::DFC_OFS_DYN_CFG);
  wire wr_route = bus_req_i.we &&
                  reg_hit(bus_req_i.addr, dfc_pkg::DFC_OFS_ROUTE_CFG);
  wire [1:0] wr_fifo = {
    bus_req_i.we && reg_hit(bus_req_i.addr, dfc_pkg::DFC_OFS_FIFO1),
    bus_req_i.we && reg_hit(bus_req_i.addr, dfc_pkg::DFC_OFS_FIFO0)};
  // Read decode
  wire [1:0] rd_fifo = {
    bus_req_i.re && reg_hit(bus_req_i.addr, dfc_pkg::DFC_OFS_FIFO1),
    bus_req_i.re && reg_hit(bus_req_i.addr, dfc_pkg::DFC_OFS_FIFO0)};
  wire [1:0] rd_acc = {
    bus_req_i.re && reg_hit(bus_req_i.addr, dfc_pkg::DFC_OFS_ACC1),
    bus_req_i.re && reg_hit(bus_req_i.addr, dfc_pkg::DFC_OFS_ACC0)};

  // Global mode bits
  wire cap_en = mode_r[dfc_pkg::DFC_MODE_CAPTURE];
  wire async_en = mode_r[dfc_pkg::DFC_MODE_ASYNC];
  wire fast_en = mode_r[dfc_pkg::DFC_MODE_FAST];
  wire edge_en = mode_r[dfc_pkg::DFC_MODE_EDGE];

  always_ff @(posedge clk_sys_i) begin
    if (!rstn_i) begin
      aux_r <= dfc_pkg::DFC_RST_AUX_CTRL;
      mode_r <= dfc_pkg::DFC_RST_MODE_CFG;
      dyn_r <= dfc_pkg::DFC_RST_DYN_CFG;
      route_r <= dfc_pkg::DFC_RST_ROUTE_CFG;
    end else begin
      if (wr_aux) begin
        aux_r <= bus_req_i.wdata;
      end
      if (wr_mode) begin
        mode_r <= bus_req_i.wdata;
      end
      if (wr_dyn) begin
        dyn_r <= bus_req_i.wdata;
      end
      if (wr_route) begin
        route_r <= bus_req_i.wdata;
      end
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (!rstn_i) begin
      dp_clk_d_r <= 1'b0;
      rd_data_r <= 8'h00;
    end else begin
      dp_clk_d_r <= dp_clk_s;
      rd_data_r <= rd_data_nxt;
    end
  end

  // Read mux; unmapped offsets and unused status bits read zero.
  // accumulator read returns the live value, not the capture
  always_comb begin
    rd_data_nxt = 8'h00;
    if (!bus_req_i.re) begin
      rd_data_nxt = 8'h00;
    end else if (reg_hit(bus_req_i.addr, dfc_pkg::DFC_OFS_AUX_CTRL)) begin
      rd_data_nxt = aux_r;
    end else if (reg_hit(bus_req_i.addr, dfc_pkg::DFC_OFS_MODE_CFG)) begin
      rd_data_nxt = mode_r;
    end else if (reg_hit(bus_req_i.addr, dfc_pkg::DFC_OFS_DYN_CFG)) begin
      rd_data_nxt = dyn_r;
    end else if (reg_hit(bus_req_i.addr, dfc_pkg::DFC_OFS_ROUTE_CFG)) begin
      rd_data_nxt = route_r;
    end else if (rd_acc[0]) begin
      rd_data_nxt = dp_data_i.acc0;
    end else if (rd_acc[1]) begin
      rd_data_nxt = dp_data_i.acc1;
    end else if (rd_fifo[0]) begin
      rd_data_nxt = fifo_rdata[0];
    end else if (rd_fifo[1]) begin
      rd_data_nxt = fifo_rdata[1];
    end else if (reg_hit(bus_req_i.addr, dfc_pkg::DFC_OFS_STATUS)) begin
      rd_data_nxt[dfc_pkg::DFC_STAT_HOST_LSB +: 2] = host_stat_r;
      rd_data_nxt[dfc_pkg::DFC_STAT_INT_LSB +: 2] = int_stat_r;
    end
  end

  genvar g;
  generate
    for (g = 0; g < 2; g++) begin : gen_fifo
      logic sw_pend_r;
      logic req_prev_r;
      logic int_d1_r;
      logic int_d2_r;
      logic [7:0] src_data;
      logic [7:0] wdata;

      wire flush = aux_r[dfc_pkg::DFC_AUX_FLUSH_LSB + g];
      wire level_sel = aux_r[dfc_pkg::DFC_AUX_LEVEL_LSB + g];
      wire clk_inv = mode_r[dfc_pkg::DFC_MODE_INVERT_LSB + g];
      wire dyn = dyn_r[dfc_pkg::DFC_DYN_LSB + g];
      wire [1:0] src_sel = route_r[dfc_pkg::DFC_ROUTE_LSB + 2*g +: 2];
      // Static direction; flush leaves it in force
      wire is_out = (src_sel != dfc_pkg::DFC_SRC_BUS);

      // dynamic access chosen by routed select
      // select high is external, low internal
      wire ext = access_sel_s[g];
      wire bus_wr_ok = dyn ? ext : !is_out;
      wire bus_rd_ok = dyn ? ext : is_out;
      wire dp_wr_ok = dyn ? !ext : is_out;
      // internal reads feed the accumulator only
      wire dp_rd_ok = dyn ? !ext : !is_out;

      // inverted FIFO clock uses falling edge
      wire tick = clk_inv ? dp_fall : dp_rise;
      // fast mode samples every system clock, for output-routed FIFOs only
      wire sample = (fast_en && is_out) ? 1'b1 : tick;

      wire sw_hit = cap_en && is_out &&
                    (rd_acc[g] || capture_chain_i[g]);
      wire req = hw_load_strobe_i[g] || sw_hit || sw_pend_r;
      // edge mode needs a low sample first
      wire load = sample && req && !(edge_en && req_prev_r);

      wire dp_wr = load && dp_wr_ok;
      wire dp_rd = tick && dp_read_i[g] && dp_rd_ok;
      wire bus_wr = wr_fifo[g] && bus_wr_ok;
      wire fifo_wr = bus_wr || dp_wr;
      wire fifo_rd = (rd_fifo[g] && bus_rd_ok) || dp_rd;

      // bus source code falls to the default, the ALU value
      always_comb begin
        src_data = dp_data_i.alu;
        case (src_sel)
          dfc_pkg::DFC_SRC_ACC0: src_data = dp_data_i.acc0;
          dfc_pkg::DFC_SRC_ACC1: src_data = dp_data_i.acc1;
          default: src_data = dp_data_i.alu;
        endcase
        wdata = bus_wr ? bus_req_i.wdata : src_data;
      end

      // flush held gives a one-byte buffer
      dfc_byte_fifo u_fifo (
        .clk_sys_i(clk_sys_i),
        .rstn_i(rstn_i),
        .flush_i(flush),
        .wr_i(fifo_wr),
        .wdata_i(wdata),
        .rd_i(fifo_rd),
        .rdata_o(fifo_rdata[g]),
        .count_o(fifo_count[g])
      );

      // level bit picks one or two bytes
      wire [2:0] thr = level_sel ? dfc_pkg::DFC_THR_HIGH
                                 : dfc_pkg::DFC_THR_LOW;
      wire [2:0] room = 3'(dfc_pkg::DFC_FIFO_DEPTH - fifo_count[g]);
      wire full = (fifo_count[g] == dfc_pkg::DFC_FIFO_DEPTH);
      wire empty = (fifo_count[g] == 3'h0);
      wire read_side = is_out || dyn;
      wire host_raw = read_side ? (fifo_count[g] >= thr)
                                : (room >= thr);
      wire int_raw = read_side ? full : empty;
      // set at once, clear seen late
      wire int_stat = int_raw || (async_en && int_d2_r);

      always_ff @(posedge clk_sys_i) begin
        if (!rstn_i) begin
          sw_pend_r <= 1'b0;
          req_prev_r <= 1'b0;
          int_d1_r <= 1'b0;
          int_d2_r <= 1'b0;
          host_stat_r[g] <= 1'b0;
          int_stat_r[g] <= 1'b0;
          wr_pulse_r[g] <= 1'b0;
          chain_r[g] <= 1'b0;
          fifo_data_r[g] <= 8'h00;
        end else begin
          // Capture held until a sample point; new one wins
          sw_pend_r <= sw_hit || (sw_pend_r && !sample);
          if (sample) begin
            req_prev_r <= req;
          end
          int_d1_r <= int_raw;
          int_d2_r <= int_d1_r;
          host_stat_r[g] <= host_raw && !flush;
          int_stat_r[g] <= int_stat && !flush;
          wr_pulse_r[g] <= fifo_wr;
          chain_r[g] <= cap_en && (rd_acc[g] || capture_chain_i[g]);
          fifo_data_r[g] <= fifo_rdata[g];
        end
      end
    end
  endgenerate

  // flush before capture is left to firmware
  assign rd_data_o = rd_data_r;
  assign fifo_data_o = fifo_data_r;
  assign host_side_status_o = host_stat_r;
  assign internal_side_status_o = int_stat_r;
  assign fifo_write_pulse_o = wr_pulse_r;
  assign capture_chain_o = chain_r;

endmodule

// *** verilog/dfc_pkg.sv ***
package dfc_pkg;

  // Register bus
  localparam int unsigned DFC_AW = 4;
  localparam int unsigned DFC_DW = 8;

  // Register offsets
  localparam logic [3:0] DFC_OFS_AUX_CTRL = 4'h0;
  localparam logic [3:0] DFC_OFS_MODE_CFG = 4'h1;
  localparam logic [3:0] DFC_OFS_DYN_CFG = 4'h2;
  localparam logic [3:0] DFC_OFS_ROUTE_CFG = 4'h3;
  localparam logic [3:0] DFC_OFS_ACC0 = 4'h4;
  localparam logic [3:0] DFC_OFS_ACC1 = 4'h5;
  localparam logic [3:0] DFC_OFS_FIFO0 = 4'h6;
  localparam logic [3:0] DFC_OFS_FIFO1 = 4'h7;
  localparam logic [3:0] DFC_OFS_STATUS = 4'h8;

  // Field positions: auxiliary_control
  localparam int unsigned DFC_AUX_FLUSH_LSB = 0;
  localparam int unsigned DFC_AUX_LEVEL_LSB = 2;
  // Field positions: fifo_mode_config
  localparam int unsigned DFC_MODE_CAPTURE = 0;
  localparam int unsigned DFC_MODE_ASYNC = 1;
  localparam int unsigned DFC_MODE_INVERT_LSB = 2;
  localparam int unsigned DFC_MODE_FAST = 4;
  localparam int unsigned DFC_MODE_EDGE = 5;
  // Field positions: fifo_dynamic_config
  localparam int unsigned DFC_DYN_LSB = 0;
  // Field positions: fifo_route_config, two bits per FIFO
  localparam int unsigned DFC_ROUTE_LSB = 0;
  // Field positions: status
  localparam int unsigned DFC_STAT_HOST_LSB = 0;
  localparam int unsigned DFC_STAT_INT_LSB = 2;

  // Reset values
  localparam logic [7:0] DFC_RST_AUX_CTRL = 8'h00;
  localparam logic [7:0] DFC_RST_MODE_CFG = 8'h00;
  localparam logic [7:0] DFC_RST_DYN_CFG = 8'h00;
  localparam logic [7:0] DFC_RST_ROUTE_CFG = 8'h00;

  // FIFO geometry and thresholds
  localparam int unsigned DFC_FIFO_W = 8;
  localparam logic [2:0] DFC_FIFO_DEPTH = 3'h4;
  localparam logic [2:0] DFC_THR_LOW = 3'h1;
  localparam logic [2:0] DFC_THR_HIGH = 3'h2;

  // Source selection of a FIFO
  typedef enum logic [1:0] {
    DFC_SRC_BUS = 2'h0,
    DFC_SRC_ACC0 = 2'h1,
    DFC_SRC_ACC1 = 2'h2,
    DFC_SRC_ALU = 2'h3
  } dfc_src_t;

  // Register bus request
  typedef struct packed {
    logic we;
    logic re;
    logic [DFC_AW-1:0] addr;
    logic [DFC_DW-1:0] wdata;
  } dfc_bus_req_t;

  // Datapath operands offered to the FIFOs
  typedef struct packed {
    logic [DFC_FIFO_W-1:0] alu;
    logic [DFC_FIFO_W-1:0] acc1;
    logic [DFC_FIFO_W-1:0] acc0;
  } dfc_dp_data_t;

endpackage

// *** verilog/dfc_sync.sv ***
`timescale 1ns/10ps
module dfc_sync #(
  parameter int unsigned WIDTH = 3
) (
  input wire logic clk_sys_i,
  input wire logic rstn_i,
  input wire logic [WIDTH-1:0] d_i,
  output logic [WIDTH-1:0] q_o
);

  logic [WIDTH-1:0] meta_r;
  logic [WIDTH-1:0] q_r;

  // First stage feeds only the second
  always_ff @(posedge clk_sys_i) begin
    if (!rstn_i) begin
      meta_r <= '0;
      q_r <= '0;
    end else begin
      meta_r <= d_i;
      q_r <= meta_r;
    end
  end

  assign q_o = q_r;

endmodule
